// ---- rtl/cap_map.vh ----
// Register addresses, field positions, reset values and mode codes of the counter array
`ifndef CAP_MAP_VH
`define CAP_MAP_VH
`define CAP_A_CNT_LO0    8'ha2
`define CAP_A_CNT_HI0    8'ha3
`define CAP_A_CTRL0      8'ha4
`define CAP_A_STATUS     8'ha5
`define CAP_A_MODE0      8'ha9
`define CAP_A_MODE1      8'haa
`define CAP_A_MODE2      8'hab
`define CAP_A_CMP_LO0    8'hac
`define CAP_A_CMP_HI0    8'had
`define CAP_A_CMP_LO1    8'haf
`define CAP_A_CMP_HI1    8'hb1
`define CAP_A_CMP_LO2    8'hb2
`define CAP_A_CMP_HI2    8'hb3
`define CAP_A_FREQ0      8'hb4
`define CAP_A_CNT_LO1    8'hba
`define CAP_A_CNT_HI1    8'hbb
`define CAP_A_CTRL1      8'hbc
`define CAP_A_MODE3      8'hbd
`define CAP_A_MODE4      8'hbe
`define CAP_A_MODE5      8'hbf
`define CAP_A_CMP_LO3    8'hc1
`define CAP_A_CMP_HI3    8'hc2
`define CAP_A_CMP_LO4    8'hc3
`define CAP_A_CMP_HI4    8'hc4
`define CAP_A_CMP_LO5    8'hc5
`define CAP_A_CMP_HI5    8'hc6
`define CAP_A_FREQ1      8'hc7
`define CAP_CTRL_EN_ALL  7
`define CAP_CTRL_RUN     6
`define CAP_CTRL_OVF_IE  5
`define CAP_CTRL_HALT    4
`define CAP_CTRL_TEN     2
`define CAP_CTRL0_MASK   8'hf7
`define CAP_CTRL1_MASK   8'h77
`define CAP_MODE_EINT    7
`define CAP_MODE_ECOMP   6
`define CAP_MODE_MATCH   3
`define CAP_PWM_FIX8     2'h1
`define CAP_PWM_PROG8    2'h2
`define CAP_PWM_WIDE     2'h3
`define CAP_CLK_PRESC    2'h0
`define CAP_CLK_T0       2'h1
`define CAP_CLK_EXT      2'h2
`define CAP_ST_BLOCK0_OVERFLOW_FLAG      3
`define CAP_ST_BLOCK1_OVERFLOW_FLAG      7
`define CAP_RST_BYTE     8'h00
`define CAP_TOP16        16'hffff
`define CAP_TOP10        16'h03ff
`endif

// ---- rtl/cap_pwm_array.v ----
// Two-block counter array with three PWM compare modules per block
// What this block does
// - Programmable 8-bit PWM: low byte matches frequency, counter clears, load registers reload.
// - One frequency register per block, shared by its three modules.
// - Each module takes duty from its own high compare byte.
// - 16-bit PWM: output high when counter is at or above compare.
// - 16-bit PWM: output low when the 16-bit counter overflows.
// - 10-bit PWM: counter and compare are 10 bits, high at or above.
// - 10-bit PWM: output low at 10-bit overflow, next pulse starts.
// - 10-bit PWM ignores the upper six bits of counter and compare high.
// - Low compare write clears comparator enable; high compare write sets it.
// - Compare zero gives full duty; all ones gives the smallest duty.
// - Comparator enable cleared gives zero duty.
// - Block 0 control bit 7 runs both counters, overriding run bits.
// - Control bit 6 runs or stops the block counter, software only.
// - Control bit 5 lets the overflow flag raise the interrupt.
// - Control bit 4 halts the block during processor idle.
// - Control bit 2 selects 10-bit over 16-bit wide PWM.
// - Control bits 1-0 pick prescaler, timer 0 overflow or external pin.
// - One status register holds both overflows and six module flags.
// - Fixed 8-bit PWM: high at duty, low-byte overflow copies high to low.
// - Two-bit PWM field picks variant and enables the pin as output.
// - All eight enabled flags are ORed into one interrupt request.
// - Module flags set by hardware on match, held until software clears.
`timescale 1ns/1ps
`include "cap_map.vh"
module cap_pwm_array (
  clk,
  sys_rst,
  sfr_addr,
  sfr_wdata,
  sfr_wr,
  sfr_rd,
  sfr_rdata,
  prescaler_tick,
  timer0_overflow,
  ext_clk_pin,
  cpu_idle,
  module_output_pin,
  module_output_en,
  irq
);
  input  wire       clk;
  input  wire       sys_rst;
  input  wire [7:0] sfr_addr;
  input  wire [7:0] sfr_wdata;
  input  wire       sfr_wr;
  input  wire       sfr_rd;
  output reg  [7:0] sfr_rdata;
  input  wire [1:0] prescaler_tick;
  input  wire       timer0_overflow;
  input  wire [1:0] ext_clk_pin;
  input  wire       cpu_idle;
  output reg  [5:0] module_output_pin;
  output reg  [5:0] module_output_en;
  output reg        irq;

  reg  [7:0]  ctrl_reg  [0:1];
  reg  [15:0] cnt_reg   [0:1];
  reg  [7:0]  freq_reg  [0:1];
  reg  [7:0]  fload_reg [0:1];
  reg  [7:0]  mode_reg  [0:5];
  reg  [7:0]  cmp_lo_reg [0:5];
  reg  [7:0]  cmp_hi_reg [0:5];
  reg  [7:0]  status_reg;
  reg  [1:0]  ext_s1_reg;
  reg  [1:0]  ext_s2_reg;
  reg  [1:0]  ext_s3_reg;

  reg  [1:0]  tick;
  reg  [1:0]  prog;
  reg  [1:0]  prog_hit;
  reg  [1:0]  low_wrap;
  reg  [1:0]  ovf_evt;
  reg  [15:0] top;
  reg  [5:0]  match_evt;
  reg  [5:0]  pin_next;
  reg  [5:0]  wr_lo;
  reg  [5:0]  wr_hi;
  reg  [5:0]  wr_mode;
  reg  [1:0]  wr_cl;
  reg  [1:0]  wr_ch;
  reg  [1:0]  wr_ctrl;
  reg  [1:0]  wr_freq;
  reg         wr_stat;
  reg  [7:0]  rd_mux;
  reg  [7:0]  st_set;
  reg         irq_next;
  reg         src;
  reg         run;
  reg  [15:0] cmp;
  reg  [15:0] cv;
  integer     b;
  integer     m;
  integer     cb;
  integer     cm;
  integer     om;

  // Modules 0-2 belong to block 0, modules 3-5 to block 1
  function integer blk;
    input integer idx;
    begin
      blk = (idx < 3) ? 0 : 1;
    end
  endfunction

  // Address decode and read mux
  always @* begin
    wr_lo   = 6'h00;
    wr_hi   = 6'h00;
    wr_mode = 6'h00;
    wr_cl   = 2'h0;
    wr_ch   = 2'h0;
    wr_ctrl = 2'h0;
    wr_freq = 2'h0;
    wr_stat = 1'b0;
    rd_mux  = 8'h00;
    case (sfr_addr)
      `CAP_A_CNT_LO0: begin wr_cl[0] = sfr_wr; rd_mux = cnt_reg[0][7:0]; end
      `CAP_A_CNT_HI0: begin wr_ch[0] = sfr_wr; rd_mux = cnt_reg[0][15:8]; end
      `CAP_A_CNT_LO1: begin wr_cl[1] = sfr_wr; rd_mux = cnt_reg[1][7:0]; end
      `CAP_A_CNT_HI1: begin wr_ch[1] = sfr_wr; rd_mux = cnt_reg[1][15:8]; end
      `CAP_A_CTRL0:   begin wr_ctrl[0] = sfr_wr; rd_mux = ctrl_reg[0]; end
      `CAP_A_CTRL1:   begin wr_ctrl[1] = sfr_wr; rd_mux = ctrl_reg[1]; end
      `CAP_A_STATUS:  begin wr_stat = sfr_wr; rd_mux = status_reg; end
      `CAP_A_FREQ0:   begin wr_freq[0] = sfr_wr; rd_mux = freq_reg[0]; end
      `CAP_A_FREQ1:   begin wr_freq[1] = sfr_wr; rd_mux = freq_reg[1]; end
      `CAP_A_MODE0:   begin wr_mode[0] = sfr_wr; rd_mux = mode_reg[0]; end
      `CAP_A_MODE1:   begin wr_mode[1] = sfr_wr; rd_mux = mode_reg[1]; end
      `CAP_A_MODE2:   begin wr_mode[2] = sfr_wr; rd_mux = mode_reg[2]; end
      `CAP_A_MODE3:   begin wr_mode[3] = sfr_wr; rd_mux = mode_reg[3]; end
      `CAP_A_MODE4:   begin wr_mode[4] = sfr_wr; rd_mux = mode_reg[4]; end
      `CAP_A_MODE5:   begin wr_mode[5] = sfr_wr; rd_mux = mode_reg[5]; end
      `CAP_A_CMP_LO0: begin wr_lo[0] = sfr_wr; rd_mux = cmp_lo_reg[0]; end
      `CAP_A_CMP_LO1: begin wr_lo[1] = sfr_wr; rd_mux = cmp_lo_reg[1]; end
      `CAP_A_CMP_LO2: begin wr_lo[2] = sfr_wr; rd_mux = cmp_lo_reg[2]; end
      `CAP_A_CMP_LO3: begin wr_lo[3] = sfr_wr; rd_mux = cmp_lo_reg[3]; end
      `CAP_A_CMP_LO4: begin wr_lo[4] = sfr_wr; rd_mux = cmp_lo_reg[4]; end
      `CAP_A_CMP_LO5: begin wr_lo[5] = sfr_wr; rd_mux = cmp_lo_reg[5]; end
      `CAP_A_CMP_HI0: begin wr_hi[0] = sfr_wr; rd_mux = cmp_hi_reg[0]; end
      `CAP_A_CMP_HI1: begin wr_hi[1] = sfr_wr; rd_mux = cmp_hi_reg[1]; end
      `CAP_A_CMP_HI2: begin wr_hi[2] = sfr_wr; rd_mux = cmp_hi_reg[2]; end
      `CAP_A_CMP_HI3: begin wr_hi[3] = sfr_wr; rd_mux = cmp_hi_reg[3]; end
      `CAP_A_CMP_HI4: begin wr_hi[4] = sfr_wr; rd_mux = cmp_hi_reg[4]; end
      `CAP_A_CMP_HI5: begin wr_hi[5] = sfr_wr; rd_mux = cmp_hi_reg[5]; end
      default:        rd_mux = 8'h00;
    endcase
  end

  // Counter clocking, wrap and reload events per block
  always @* begin
    tick     = 2'h0;
    prog     = 2'h0;
    prog_hit = 2'h0;
    low_wrap = 2'h0;
    ovf_evt  = 2'h0;
    top      = `CAP_TOP16;
    src      = 1'b0;
    run      = 1'b0;
    for (cb = 0; cb < 2; cb = cb + 1) begin
      case (ctrl_reg[cb][1:0])
        `CAP_CLK_PRESC: src = prescaler_tick[cb];
        `CAP_CLK_T0:    src = timer0_overflow;
        `CAP_CLK_EXT:   src = ext_s2_reg[cb] & ~ext_s3_reg[cb];
        default:        src = 1'b0;
      endcase
      run = ctrl_reg[cb][`CAP_CTRL_RUN] | ctrl_reg[0][`CAP_CTRL_EN_ALL];
      tick[cb] = src & run & ~(cpu_idle & ctrl_reg[cb][`CAP_CTRL_HALT]);
      for (cm = 0; cm < 6; cm = cm + 1) begin
        if (blk(cm) == cb && mode_reg[cm][1:0] == `CAP_PWM_PROG8) begin
          prog[cb] = 1'b1;
        end
      end
      top = ctrl_reg[cb][`CAP_CTRL_TEN] ? `CAP_TOP10 : `CAP_TOP16;
      prog_hit[cb] = tick[cb] & prog[cb] & (cnt_reg[cb][7:0] == fload_reg[cb]);
      low_wrap[cb] = tick[cb] & (cnt_reg[cb][7:0] == 8'hff);
      ovf_evt[cb]  = tick[cb] & ~prog_hit[cb] & ((cnt_reg[cb] & top) == top);
    end
  end

  // Per-module output level and match events
  always @* begin
    pin_next  = 6'h00;
    match_evt = 6'h00;
    cmp       = 16'h0000;
    cv        = 16'h0000;
    for (om = 0; om < 6; om = om + 1) begin
      cv  = cnt_reg[blk(om)];
      cmp = {cmp_hi_reg[om], cmp_lo_reg[om]};
      // Comparator disabled forces the pin low whatever the mode
      if (mode_reg[om][`CAP_MODE_ECOMP]) begin
        case (mode_reg[om][1:0])
          `CAP_PWM_FIX8:  pin_next[om] = (cv[7:0] >= cmp_lo_reg[om]);
          `CAP_PWM_PROG8: pin_next[om] = (cv[7:0] >= cmp_lo_reg[om]);
          `CAP_PWM_WIDE: begin
            if (ctrl_reg[blk(om)][`CAP_CTRL_TEN]) begin
              pin_next[om] = (cv[9:0] >= cmp[9:0]);
            end else begin
              pin_next[om] = (cv >= cmp);
            end
          end
          default:        pin_next[om] = 1'b0;
        endcase
        match_evt[om] = tick[blk(om)] & mode_reg[om][`CAP_MODE_MATCH] & (cv == cmp);
      end
    end
    st_set = {ovf_evt[1], match_evt[5:3], ovf_evt[0], match_evt[2:0]};
    irq_next = 1'b0;
    for (om = 0; om < 6; om = om + 1) begin
      irq_next = irq_next | (status_reg[(om < 3) ? om : om + 1] & mode_reg[om][`CAP_MODE_EINT]);
    end
    irq_next = irq_next
             | (status_reg[`CAP_ST_BLOCK0_OVERFLOW_FLAG] & ctrl_reg[0][`CAP_CTRL_OVF_IE])
             | (status_reg[`CAP_ST_BLOCK1_OVERFLOW_FLAG] & ctrl_reg[1][`CAP_CTRL_OVF_IE]);
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      for (b = 0; b < 2; b = b + 1) begin
        ctrl_reg[b]  <= `CAP_RST_BYTE;
        cnt_reg[b]   <= 16'h0000;
        freq_reg[b]  <= `CAP_RST_BYTE;
        fload_reg[b] <= `CAP_RST_BYTE;
      end
      for (m = 0; m < 6; m = m + 1) begin
        mode_reg[m]   <= `CAP_RST_BYTE;
        cmp_lo_reg[m] <= `CAP_RST_BYTE;
        cmp_hi_reg[m] <= `CAP_RST_BYTE;
      end
      status_reg        <= `CAP_RST_BYTE;
      ext_s1_reg        <= 2'h0;
      ext_s2_reg        <= 2'h0;
      ext_s3_reg        <= 2'h0;
      sfr_rdata         <= 8'h00;
      module_output_pin <= 6'h00;
      module_output_en  <= 6'h00;
      irq               <= 1'b0;
    end else begin
      // External clock edges are only seen after the second stage
      ext_s1_reg <= ext_clk_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (sfr_rd) begin
        sfr_rdata <= rd_mux;
      end
      for (b = 0; b < 2; b = b + 1) begin
        if (wr_ctrl[b]) begin
          ctrl_reg[b] <= sfr_wdata & ((b == 0) ? `CAP_CTRL0_MASK : `CAP_CTRL1_MASK);
        end
        if (wr_freq[b]) begin
          freq_reg[b] <= sfr_wdata;
        end
        if (prog_hit[b]) begin
          fload_reg[b] <= freq_reg[b];
        end else if (!prog[b]) begin
          // Track the register so the first programmable period uses it
          fload_reg[b] <= freq_reg[b];
        end
        // Software counter writes win over a tick in the same cycle
        if (wr_cl[b]) begin
          cnt_reg[b][7:0] <= sfr_wdata;
        end else if (wr_ch[b]) begin
          cnt_reg[b][15:8] <= sfr_wdata;
        end else if (prog_hit[b]) begin
          cnt_reg[b] <= 16'h0000;
        end else if (tick[b]) begin
          cnt_reg[b] <= (cnt_reg[b] + 16'h0001) &
                        (ctrl_reg[b][`CAP_CTRL_TEN] ? `CAP_TOP10 : `CAP_TOP16);
        end
      end
      for (m = 0; m < 6; m = m + 1) begin
        if (wr_mode[m]) begin
          mode_reg[m] <= sfr_wdata;
        end else if (wr_lo[m]) begin
          mode_reg[m][`CAP_MODE_ECOMP] <= 1'b0;
        end else if (wr_hi[m]) begin
          mode_reg[m][`CAP_MODE_ECOMP] <= 1'b1;
        end
        if (wr_hi[m]) begin
          cmp_hi_reg[m] <= sfr_wdata;
        end
        // A software low-byte write takes priority over the hardware reload
        if (wr_lo[m]) begin
          cmp_lo_reg[m] <= sfr_wdata;
        end else if ((mode_reg[m][1:0] == `CAP_PWM_FIX8 && low_wrap[blk(m)]) ||
                     (mode_reg[m][1:0] == `CAP_PWM_PROG8 && prog_hit[blk(m)])) begin
          cmp_lo_reg[m] <= cmp_hi_reg[m];
        end
      end
      // Hardware set wins over a software clear in the same cycle
      status_reg <= (wr_stat ? sfr_wdata : status_reg) | st_set;
      module_output_pin <= pin_next;
      for (m = 0; m < 6; m = m + 1) begin
        module_output_en[m] <= (mode_reg[m][1:0] != 2'h0);
      end
      irq <= irq_next;
    end
  end
endmodule

// ---- sim/cap_pwm_array_chk.sv ----
// Port-level assertions for the PWM counter array
`timescale 1ns/1ps
module cap_pwm_array_chk (
  input wire       clk,
  input wire       sys_rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire       sfr_wr,
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire [1:0] prescaler_tick,
  input wire       timer0_overflow,
  input wire [1:0] ext_clk_pin,
  input wire       cpu_idle,
  input wire [5:0] module_output_pin,
  input wire [5:0] module_output_en,
  input wire       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence lo_write_s;
    sfr_wr && sfr_addr == 8'hac;
  endsequence
  // Re-enable comes only from the high byte or a mode write
  sequence no_reenable_s;
    !(sfr_wr && (sfr_addr == 8'had || sfr_addr == 8'ha9));
  endsequence
  AST_COMP_OFF: assert property (
    lo_write_s ##1 no_reenable_s [*3] |-> !module_output_pin[0])
    else $error("pin high after comparator disable");
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> module_output_pin == 6'h00 && !irq)
    else $error("outputs active right after reset");
  AST_EN_ON: assert property (
    sfr_wr && sfr_addr == 8'ha9 && sfr_wdata[1:0] != 2'h0 |-> ##[1:2] module_output_en[0])
    else $error("pin not enabled by pwm field");
  AST_EN_OFF: assert property (
    sfr_wr && sfr_addr == 8'ha9 && sfr_wdata[1:0] == 2'h0 |-> ##[1:2] !module_output_en[0])
    else $error("pin still enabled with field clear");
  AST_PIN_NEEDS_EN: assert property (
    !module_output_en[0] && !$past(module_output_en[0]) |-> !module_output_pin[0])
    else $error("pin driven high without enable");
  AST_RDATA_HOLDS: assert property (
    !$past(sfr_rd) && !$past(sfr_rd, 2) |-> $stable(sfr_rdata))
    else $error("read data changed without a read");
  AST_UNMAPPED_ZERO: assert property (sfr_rd && sfr_addr == 8'h00 |-> ##2 sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTRL0_RSVD: assert property (sfr_rd && sfr_addr == 8'ha4 |-> ##2 !sfr_rdata[3])
    else $error("reserved control bit reads one");
  AST_CTRL1_B7: assert property (
    sfr_rd && sfr_addr == 8'hbc |-> ##2 !sfr_rdata[7] && !sfr_rdata[3])
    else $error("block 1 control upper bit reads one");
endmodule
bind cap_pwm_array cap_pwm_array_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .prescaler_tick(prescaler_tick),
  .timer0_overflow(timer0_overflow), .ext_clk_pin(ext_clk_pin), .cpu_idle(cpu_idle),
  .module_output_pin(module_output_pin), .module_output_en(module_output_en), .irq(irq)
);

// ---- sim/cap_pin_load.sv ----
// Load model on the PWM pins: counts cycles with module 0 driving high
`timescale 1ns/1ps
module cap_pin_load (
  input  wire       clk,
  input  wire [5:0] pin,
  input  wire [5:0] pin_en,
  output integer    high_cycles
);
  initial high_cycles = 0;
  // A pin without its enable floats, so only driven highs reach the load
  always @(posedge clk) begin
    if (pin[0] && pin_en[0]) high_cycles <= high_cycles + 1;
  end
endmodule

// ---- sim/test_cap_pwm_array.sv ----
// Self-checking bench for the two-block PWM counter array
`timescale 1ns/1ps
`include "cap_map.vh"
module test_cap_pwm_array;
  reg        clk;
  reg        sys_rst;
  reg  [7:0] sfr_addr;
  reg  [7:0] sfr_wdata;
  reg        sfr_wr;
  reg        sfr_rd;
  reg  [1:0] prescaler_tick;
  reg        timer0_overflow;
  reg  [1:0] ext_clk_pin;
  reg        cpu_idle;
  wire [7:0] sfr_rdata;
  wire [5:0] pin;
  wire [5:0] pin_en;
  wire       irq;
  reg  [7:0] rd_val;
  reg [31:0] lfsr;
  reg        e;
  integer    high_cycles;
  integer    errors;
  integer    tests_run;
  integer    cnt0, cmp0, act0, mode, block0_overflow_flag, top, h0, i, k;
  cap_pwm_array dut (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .prescaler_tick(prescaler_tick),
    .timer0_overflow(timer0_overflow), .ext_clk_pin(ext_clk_pin), .cpu_idle(cpu_idle),
    .module_output_pin(pin), .module_output_en(pin_en), .irq(irq)
  );
  cap_pin_load load (.clk(clk), .pin(pin), .pin_en(pin_en), .high_cycles(high_cycles));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    summarize;
  end
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      #1 sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk);
      #1 sfr_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      #1 sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk);
      #1 sfr_rd = 1'b0;
      @(posedge clk);
      #1 rd_val = sfr_rdata;
    end
  endtask
  // Sources: 0 prescaler 0, 1 timer 0, 2 external pin 0, 3 prescaler 1
  task pulse(input integer src);
    begin
      @(posedge clk);
      #1 prescaler_tick = (src == 0) ? 2'h1 : (src == 3) ? 2'h2 : 2'h0;
      timer0_overflow = (src == 1);
      ext_clk_pin[0] = (src == 2);
      @(posedge clk);
      #1 prescaler_tick = 2'h0;
      timer0_overflow = 1'b0;
      // The external pin is synchronised, so hold it long enough to be seen
      repeat (4) @(posedge clk);
      #1 ext_clk_pin = 2'h0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task step;
    begin
      pulse(0);
      cnt0 = (cnt0 + 1) % top;
      if (cnt0 == 0 && mode < 2) block0_overflow_flag = 1;
      if (mode == 2 && cnt0 % 256 == 0) act0 = cmp0 / 256;
      e = (mode == 2) ? (cnt0 % 256 >= act0) : (cnt0 >= cmp0 % top);
      chk({7'h0, pin[0]}, {7'h0, e});
    end
  endtask
  task pwm(input [7:0] ctl, input [7:0] md, input [15:0] cv, input [15:0] cp, input integer m);
    begin
      mode = m;
      top = (m == 1) ? 1024 : 65536;
      wr(`CAP_A_CTRL0, 8'h00);
      wr(`CAP_A_MODE0, md);
      // The 10-bit width is shared, so the whole block goes there together
      if (m == 1) begin
        wr(`CAP_A_MODE1, md);
        wr(`CAP_A_MODE2, md);
      end
      wr(`CAP_A_CNT_LO0, cv[7:0]);
      wr(`CAP_A_CNT_HI0, cv[15:8]);
      wr(`CAP_A_CMP_LO0, cp[7:0]);
      wr(`CAP_A_CMP_HI0, cp[15:8]);
      wr(`CAP_A_STATUS, 8'h00);
      wr(`CAP_A_CTRL0, ctl);
      cnt0 = cv % top;
      cmp0 = cp;
      act0 = cp % 256;
      block0_overflow_flag = 0;
      for (k = 0; k < 20; k = k + 1) step;
      rd(`CAP_A_STATUS);
      chk({7'h0, rd_val[3]}, {7'h0, block0_overflow_flag[0]});
      chk({7'h0, irq}, {7'h0, block0_overflow_flag[0] & ctl[5]});
      $display("test pwm mode %0d done", m);
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    prescaler_tick = 2'h0;
    timer0_overflow = 1'b0;
    ext_clk_pin = 2'h0;
    cpu_idle = 1'b0;
    errors = 0;
    tests_run = 0;
    lfsr = 32'h49e1;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(`CAP_A_STATUS);
    chk(rd_val, 8'h00);
    wr(`CAP_A_CTRL0, 8'hff);
    rd(`CAP_A_CTRL0);
    chk(rd_val, 8'hf7);
    wr(`CAP_A_CTRL1, 8'hff);
    rd(`CAP_A_CTRL1);
    chk(rd_val, 8'h77);
    wr(8'h00, 8'hff);
    rd(8'h00);
    chk(rd_val, 8'h00);
    wr(`CAP_A_CTRL1, 8'h00);
    $display("test registers done");
    for (i = 0; i < 3; i = i + 1) begin
      wr(`CAP_A_CTRL0, 8'h40 | i[7:0]);
      wr(`CAP_A_CNT_LO0, 8'h00);
      for (k = 0; k < 3; k = k + 1) pulse(k);
      rd(`CAP_A_CNT_LO0);
      chk(rd_val, 8'h01);
    end
    wr(`CAP_A_CTRL0, 8'h50);
    cpu_idle = 1'b1;
    pulse(0);
    wr(`CAP_A_CTRL0, 8'h40);
    pulse(0);
    cpu_idle = 1'b0;
    wr(`CAP_A_CTRL0, 8'h00);
    pulse(0);
    rd(`CAP_A_CNT_LO0);
    chk(rd_val, 8'h02);
    wr(`CAP_A_CTRL0, 8'h80);
    pulse(3);
    pulse(0);
    rd(`CAP_A_CNT_LO1);
    chk(rd_val, 8'h01);
    rd(`CAP_A_CNT_LO0);
    chk(rd_val, 8'h03);
    $display("test clocking done");
    for (i = 0; i < 3; i = i + 1) begin
      lfsr = lfsr_next(lfsr);
      cmp0 = (i == 0) ? 16'hffff : (i == 1) ? {12'hfff, lfsr[3:0]} : 16'h0000;
      pwm(8'h60, 8'h43, 16'hfff0, cmp0[15:0], 0);
    end
    wr(`CAP_A_STATUS, 8'h00);
    rd(`CAP_A_STATUS);
    chk(rd_val, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(`CAP_A_CMP_LO0, 8'h00);
    repeat (3) @(posedge clk);
    #1 h0 = high_cycles;
    for (k = 0; k < 3; k = k + 1) pulse(0);
    chk({7'h0, pin[0]}, 8'h00);
    chk({7'h0, high_cycles != h0}, 8'h00);
    $display("test comparator disable done");
    pwm(8'h64, 8'h43, 16'hfffa, 16'hfffc, 1);
    pwm(8'h40, 8'h41, 16'h00f8, 16'h03fa, 2);
    wr(`CAP_A_CTRL0, 8'h00);
    wr(`CAP_A_FREQ0, 8'h05);
    for (i = 0; i < 3; i = i + 1) wr(8'ha9 + i[7:0], 8'h42);
    wr(`CAP_A_CMP_HI0, 8'h02);
    wr(`CAP_A_CMP_HI1, 8'h04);
    // Start from zero so the period is the frequency value plus one
    wr(`CAP_A_CNT_LO0, 8'h00);
    wr(`CAP_A_CNT_HI0, 8'h00);
    wr(`CAP_A_CTRL0, 8'h40);
    cnt0 = 0;
    for (k = 0; k < 20; k = k + 1) begin
      pulse(0);
      cnt0 = (cnt0 == 5) ? 0 : cnt0 + 1;
      // Duties only hold from the first frequency match on
      if (k > 5) chk({6'h0, pin[1:0]}, {6'h0, cnt0 >= 4, cnt0 >= 2});
    end
    rd(`CAP_A_CNT_LO0);
    chk(rd_val, cnt0[7:0]);
    chk({5'h0, pin_en[2:0]}, 8'h07);
    wr(`CAP_A_MODE0, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({7'h0, pin_en[0]}, 8'h00);
    $display("test programmable pwm done");
    summarize;
  end
endmodule
